/* File: serializer_consts.svh */
// timing, width and reset constants for the sample lane serializer
`ifndef SERIALIZER_CONSTS_SVH
`define SERIALIZER_CONSTS_SVH

`define SAMPLE_BITS 12
`define NUM_CHANNELS 4
`define SLOTS_SINGLE 4'hb
`define SLOTS_DUAL 4'h5
`define HALF_FRAME_SINGLE 4'h6
`define HALF_FRAME_DUAL 4'h3
`define HIGH_LANE_OFFSET 4'h6
`define BUFFER_DEPTH 2
`define DUAL_LANE_RESET 1'b1

`endif

/* File: serializer_pkg.sv */
// types shared by the sample lane serializer and its buffer
`include "serializer_consts.svh"

package serializer_pkg;

    typedef struct packed {
        logic [`NUM_CHANNELS-1:0][`SAMPLE_BITS-1:0] ch;
    } sample_s;

    typedef enum logic {
        LANE_SINGLE,
        LANE_DUAL
    } lane_mode_e;

    typedef enum logic {
        LINK_WAIT,
        LINK_RUN
    } link_state_e;

endpackage

/* File: sample_buffer.sv */
// two-entry valid/ready buffer for converted sample sets
`timescale 1ns/1ps
`include "serializer_consts.svh"

module sample_buffer
    import serializer_pkg::*;
(
    input wire logic sys_clk, // core clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic in_valid, // producer offers a sample set
    output logic in_ready, // room for one more set
    input wire sample_s in_data, // offered sample set
    output logic out_valid, // a set is waiting
    input wire logic out_ready, // consumer takes the set
    output sample_s out_data // oldest set
);

    sample_s mem_r [`BUFFER_DEPTH];
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [1:0] count_r;
    logic [1:0] count_nxt;
    logic push;
    logic pop;

    assign out_valid = (count_r != 2'h0);
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + 2'h1;
        end else if (pop && !push) begin
            count_nxt = count_r - 2'h1;
        end
    end

    // ready is a flop so the producer never sees a combinational path
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count_r <= 2'h0;
            in_ready <= 1'b0;
        end else begin
            count_r <= count_nxt;
            in_ready <= (count_nxt != 2'h2);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < `BUFFER_DEPTH; g = g + 1) begin : gen_entry
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    mem_r[g] <= '0;
                end else if (push && (wr_ptr_r == 1'(g))) begin
                    mem_r[g] <= in_data;
                end
            end
        end
    endgenerate

endmodule

/* File: adc_lane_serializer.sv */
// serializer of four 12-bit sample channels onto ddr data lanes with frame and bit clocks
`timescale 1ns/1ps
// Function
// - bit timing comes from the pll-multiplied sampling clock; 12-bit words serialized
// - frame clock and bit clock are driven as differential outputs with data
// - single-lane: 12x serialization, one frame period per sample, ddr bit clock
// - dual-lane: 6x serialization per lane, one frame period per sample, ddr clock
// - lane format is a control setting written by the controlling party
// - after reset the format is dual-lane; mode_r resets to dual, but the first frame already takes dual_lane_sel
// - single-lane: whole sample on the channel's own single pair
// - a new data bit follows every rising and falling bit clock edge
// - single-lane: word starts at frame clock rise, lsb first
// - single-lane lane rate is twelve times sampling rate
// - dual-lane: six bits per lane per sample, six times sampling rate
// - dual-lane: upper six bits on high lane, lower six on low lane

`include "serializer_consts.svh"

module adc_lane_serializer
    import serializer_pkg::*;
(
    input wire logic sys_clk, // core clock, 250 mhz
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic pll_bit_clk, // multiplied sampling clock, asynchronous
    input wire logic dual_lane_sel, // control setting: 1 dual-lane, 0 single-lane
    input wire logic s_valid, // converted sample set offered
    output logic s_ready, // buffer accepts the set
    input wire sample_s s_data, // four 12-bit conversion results
    output logic [`NUM_CHANNELS-1:0] high_bits_lane_pos, // high-order lanes, true
    output logic [`NUM_CHANNELS-1:0] high_bits_lane_neg, // high-order lanes, complement
    output logic [`NUM_CHANNELS-1:0] low_bits_lane_pos, // low-order lanes, true
    output logic [`NUM_CHANNELS-1:0] low_bits_lane_neg, // low-order lanes, complement
    output logic frame_clk_pos, // frame clock, true
    output logic frame_clk_neg, // frame clock, complement
    output logic bit_clk_pos, // ddr bit clock, true
    output logic bit_clk_neg // ddr bit clock, complement
);

    // ***********************************************************
    // sample buffer
    // ***********************************************************
    logic buf_valid;
    logic buf_take;
    sample_s buf_data;

    sample_buffer u_buffer (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(s_valid),
        .in_ready(s_ready),
        .in_data(s_data),
        .out_valid(buf_valid),
        .out_ready(buf_take),
        .out_data(buf_data)
    );

    // ***********************************************************
    // bit clock capture
    // ***********************************************************
    logic clk_meta_r;
    logic clk_sync_r;
    logic clk_prev_r;
    logic clk_edge;
    logic clk_rise;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            clk_meta_r <= 1'b0;
            clk_sync_r <= 1'b0;
            clk_prev_r <= 1'b0;
        end else begin
            clk_meta_r <= pll_bit_clk;
            clk_sync_r <= clk_meta_r;
            clk_prev_r <= clk_sync_r;
        end
    end

    // first stage may be metastable, so only the second and third feed logic
    // both edges step
    assign clk_edge = clk_sync_r ^ clk_prev_r;
    assign clk_rise = clk_sync_r & ~clk_prev_r;

    // ***********************************************************
    // frame sequencing
    // ***********************************************************
    link_state_e link_state_r;
    lane_mode_e mode_r;
    logic [3:0] idx_r;
    logic [3:0] last_slot;
    logic [3:0] half_frame;
    logic frame_load;
    sample_s word_r;

    // twelve bits per sample on one lane
    // six bits per lane per sample
    assign last_slot = (mode_r == LANE_DUAL) ? `SLOTS_DUAL : `SLOTS_SINGLE;
    assign half_frame = (mode_r == LANE_DUAL) ? `HALF_FRAME_DUAL : `HALF_FRAME_SINGLE;

    // frames open on a rising edge
    // slot counts are even, so a reload always lands on a rise
    always_comb begin
        case (link_state_r)
            LINK_WAIT: frame_load = clk_rise;
            LINK_RUN: frame_load = clk_edge && (idx_r >= last_slot);
            default: frame_load = 1'b0;
        endcase
    end

    assign buf_take = frame_load & buf_valid;

    // ***********************************************************
    // link state and lane format
    // ***********************************************************
    // link waits for the first rise so slot 0 lands on a rising edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            link_state_r <= LINK_WAIT;
        end else if (clk_rise) begin
            link_state_r <= LINK_RUN;
        end
    end

    // setting applied at frame boundary
    // a change mid-frame would split a word across formats
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mode_r <= (`DUAL_LANE_RESET) ? LANE_DUAL : LANE_SINGLE;
        end else if (frame_load) begin
            mode_r <= dual_lane_sel ? LANE_DUAL : LANE_SINGLE;
        end
    end

    // ***********************************************************
    // slot counter and word hold
    // ***********************************************************

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            idx_r <= 4'h0;
        end else if (frame_load) begin
            idx_r <= 4'h0;
        end else if (clk_edge && link_state_r == LINK_RUN) begin
            idx_r <= idx_r + 4'h1;
        end
    end

    // an empty buffer repeats the last word rather than stopping the link
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            word_r <= '0;
        end else if (buf_take) begin
            word_r <= buf_data;
        end
    end

    // ***********************************************************
    // lane drivers
    // ***********************************************************
    logic [3:0] high_idx;
    logic running;

    assign high_idx = idx_r + `HIGH_LANE_OFFSET;
    assign running = (link_state_r == LINK_RUN);

    genvar g;
    generate
        for (g = 0; g < `NUM_CHANNELS; g = g + 1) begin : gen_lane
            logic low_bit;
            logic high_bit;

            // lsb first on the low lane
            assign low_bit = running & word_r.ch[g][idx_r];
            // upper six on the high lane
            // single-lane holds the high lane low
            assign high_bit = running & (mode_r == LANE_DUAL) & word_r.ch[g][high_idx];

            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    low_bits_lane_pos[g] <= 1'b0;
                    low_bits_lane_neg[g] <= 1'b1;
                    high_bits_lane_pos[g] <= 1'b0;
                    high_bits_lane_neg[g] <= 1'b1;
                end else begin
                    low_bits_lane_pos[g] <= low_bit;
                    low_bits_lane_neg[g] <= ~low_bit;
                    high_bits_lane_pos[g] <= high_bit;
                    high_bits_lane_neg[g] <= ~high_bit;
                end
            end
        end
    endgenerate

    // ***********************************************************
    // clock outputs
    // ***********************************************************
    logic frame_level;

    // high for first half of the frame
    assign frame_level = running & (idx_r < half_frame);

    // differential frame and bit clocks
    // bit clock taken from the stage that steps the slot count,
    // so its edges land with the registered lane bits
    // before the first frame: pos low, neg high
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            frame_clk_pos <= 1'b0;
            frame_clk_neg <= 1'b1;
            bit_clk_pos <= 1'b0;
            bit_clk_neg <= 1'b1;
        end else begin
            frame_clk_pos <= frame_level;
            frame_clk_neg <= ~frame_level;
            bit_clk_pos <= running & clk_prev_r;
            bit_clk_neg <= ~(running & clk_prev_r);
        end
    end

endmodule

/* File: serializer_props.sv */
// concurrent checks on the lane serializer ports
`timescale 1ns/1ps
module serializer_props
    import serializer_pkg::*;
(
    input wire logic sys_clk, sys_rst, pll_bit_clk, s_valid, s_ready, // control
    input wire logic [3:0] high_bits_lane_pos, high_bits_lane_neg, // high lanes
    input wire logic [3:0] low_bits_lane_pos, low_bits_lane_neg, // low lanes
    input wire logic frame_clk_pos, frame_clk_neg, bit_clk_pos, bit_clk_neg // clocks
);
    logic [3:0] tog_r, half_r;
    logic seen_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // bit clock toggles since the frame rose
    always_ff @(posedge sys_clk) begin
        if (sys_rst || $rose(frame_clk_pos)) begin
            tog_r <= {3'h0, !sys_rst};
        end else if ($changed(bit_clk_pos)) begin
            tog_r <= tog_r + 4'h1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            seen_r <= 1'h0;
        end else if ($fell(frame_clk_pos)) begin
            seen_r <= 1'h1;
            half_r <= tog_r;
        end
    end
    chk_bit_follow: assert property ($rose(pll_bit_clk) |-> ##[1:5] $rose(bit_clk_pos))
        else $error("bit clock missed a link edge");
    chk_lane_pairs: assert property (high_bits_lane_neg == ~high_bits_lane_pos &&
        low_bits_lane_neg == ~low_bits_lane_pos) else $error("lane pair mismatch");
    chk_clock_pairs: assert property (frame_clk_neg == ~frame_clk_pos &&
        bit_clk_neg == ~bit_clk_pos) else $error("clock pair mismatch");
    chk_reset_idle: assert property (disable iff (1'h0) sys_rst |=> !bit_clk_pos &&
        !frame_clk_pos && !s_ready && low_bits_lane_pos == 4'h0)
        else $error("outputs busy after reset");
    chk_frame_start: assert property ($rose(frame_clk_pos) |-> $rose(bit_clk_pos))
        else $error("frame rose off a bit clock rise");
    chk_frame_high: assert property ($fell(frame_clk_pos) |-> tog_r inside {4'h3, 4'h6})
        else $error("frame high length wrong");
    chk_frame_len: assert property ($rose(frame_clk_pos) && seen_r |-> tog_r == 2 * half_r)
        else $error("frame period wrong");
    chk_data_edge: assert property ($changed(low_bits_lane_pos) |-> $changed(bit_clk_pos))
        else $error("data moved off a bit clock edge");
    cover property ($fell(frame_clk_pos) && tog_r == 4'h3);
    cover property ($fell(frame_clk_pos) && tog_r == 4'h6);
    cover property (s_valid && !s_ready);
endmodule
bind adc_lane_serializer serializer_props chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .pll_bit_clk(pll_bit_clk), .s_valid(s_valid), .s_ready(s_ready),
    .high_bits_lane_pos(high_bits_lane_pos), .high_bits_lane_neg(high_bits_lane_neg),
    .low_bits_lane_pos(low_bits_lane_pos), .low_bits_lane_neg(low_bits_lane_neg),
    .frame_clk_pos(frame_clk_pos), .frame_clk_neg(frame_clk_neg),
    .bit_clk_pos(bit_clk_pos), .bit_clk_neg(bit_clk_neg));

/* File: lane_receiver.sv */
// receiver model rebuilding sample sets from the lanes
`timescale 1ns/1ps
module lane_receiver
    import serializer_pkg::*;
(
    input wire logic sys_clk, sys_rst, frame_clk_pos, bit_clk_pos, // clocks
    input wire logic [3:0] high_bits_lane_pos, low_bits_lane_pos, // lanes
    output sample_s rx_word, // rebuilt set
    output logic rx_got, rx_dual, rx_hi_err // new set, six slots, high lane busy
);
    logic bc_q, fr_q, seen_r;
    logic [3:0][11:0] lo_r, hi_r;
    int k;
    // both bit clock edges, words aligned to frame rise
    always @(posedge sys_clk) begin
        rx_got <= 1'h0;
        bc_q <= bit_clk_pos;
        fr_q <= frame_clk_pos;
        if (sys_rst) begin
            seen_r <= 1'h0;
            rx_hi_err <= 1'h0;
        end else if (bit_clk_pos != bc_q) begin
            if (frame_clk_pos && !fr_q) begin
                // slot count gives the mode, so a switch needs no hint
                if (seen_r && (k == 5 || k == 11)) begin
                    rx_got <= 1'h1;
                    rx_dual <= k == 5;
                    rx_hi_err <= rx_hi_err || (k == 11 && hi_r != 48'h0);
                    for (int g = 0; g < 4; g++) begin
                        rx_word.ch[g] <= k == 5 ? {hi_r[g][5:0], lo_r[g][5:0]} : lo_r[g];
                    end
                end
                seen_r <= 1'h1;
                k = -1;
            end
            k = k + 1;
            for (int g = 0; g < 4 && k < 12; g++) begin
                lo_r[g][k] <= low_bits_lane_pos[g];
                hi_r[g][k] <= high_bits_lane_pos[g];
            end
        end
    end
endmodule

/* File: tb.sv */
// bench for the lane serializer with a receiver model
`timescale 1ns/1ps
module tb;
    import serializer_pkg::*;
    logic sys_clk, sys_rst, pll_bit_clk, dual_lane_sel, s_valid, s_ready;
    logic rx_got, rx_dual, rx_hi_err, fp, fn, bp, bn;
    logic [3:0] hp, hn, lp, ln;
    sample_s s_data, rx_word, last_w;
    int fails = 0;
    int checked = 0;
    adc_lane_serializer dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .pll_bit_clk(pll_bit_clk),
        .dual_lane_sel(dual_lane_sel), .s_valid(s_valid), .s_ready(s_ready), .s_data(s_data),
        .high_bits_lane_pos(hp), .high_bits_lane_neg(hn), .low_bits_lane_pos(lp),
        .low_bits_lane_neg(ln), .frame_clk_pos(fp), .frame_clk_neg(fn), .bit_clk_pos(bp),
        .bit_clk_neg(bn));
    lane_receiver rx_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .frame_clk_pos(fp),
        .bit_clk_pos(bp), .high_bits_lane_pos(hp), .low_bits_lane_pos(lp), .rx_word(rx_word),
        .rx_got(rx_got), .rx_dual(rx_dual), .rx_hi_err(rx_hi_err));
    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        pll_bit_clk = 1'h0;
        #3.3;
        forever #16 pll_bit_clk = ~pll_bit_clk;
    end
    task automatic stop_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // run should end well inside 3000 cycles
    initial begin
        repeat (3000) @(posedge sys_clk);
        fails++;
        stop_test();
    end
    task automatic cmp(input string what, input logic [47:0] exp, input logic [47:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic push(input sample_s d);
        @(posedge sys_clk) #1 s_valid = 1'h1;
        s_data = d;
        while (s_ready !== 1'h1) @(posedge sys_clk) #1;
        @(posedge sys_clk) #1 s_valid = 1'h0;
    endtask
    // repeats of the last set mean an empty buffer, not a new word
    task automatic take(input sample_s exp);
        do @(posedge sys_clk) #1; while (rx_got !== 1'h1 || rx_word === last_w);
        cmp("set", exp, rx_word);
        last_w = rx_word;
    endtask
    task automatic test_dual_fill;
        @(posedge fp);
        push({12'h123, 12'h456, 12'h789, 12'habc});
        push({12'hfed, 12'h0c1, 12'h802, 12'h3f4});
        cmp("room", 48'h0, {47'h0, s_ready});
        fork
            push({4{12'h5a6}});
            begin
                take({12'h123, 12'h456, 12'h789, 12'habc});
                take({12'hfed, 12'h0c1, 12'h802, 12'h3f4});
                take({4{12'h5a6}});
            end
        join
        cmp("dual", 48'h1, {47'h0, rx_dual});
    endtask
    task automatic test_single;
        // controlling side picks the lane format
        @(posedge sys_clk) #1 dual_lane_sel = 1'h0;
        push({12'h0f1, 12'h2e3, 12'h4d5, 12'h6c7});
        push({12'h801, 12'h040, 12'h002, 12'hfff});
        take({12'h0f1, 12'h2e3, 12'h4d5, 12'h6c7});
        take({12'h801, 12'h040, 12'h002, 12'hfff});
        cmp("single", 48'h0, {46'h0, rx_dual, rx_hi_err});
    endtask
    initial begin
        sys_rst = 1'h1;
        // low-rate bits are the controller's, kept outside this block
        dual_lane_sel = 1'h1;
        s_valid = 1'h0;
        s_data = 48'h0;
        last_w = 48'h0;
        repeat (5) @(posedge sys_clk);
        #1;
        sys_rst = 1'h0;
        test_dual_fill();
        test_single();
        stop_test();
    end
endmodule
